//--- famr_pkg.sv
// Purpose: constants and carriers for the fault/alert mask register bank
// Assumes: byte-wide command-code register access from a host interface
// Notes:   offsets are command codes, one byte per register
package famr_pkg;

	// ****************
	// register command codes
	// ****************
	localparam logic [7:0] ALERT_MASK_CMD   = 8'hf9;
	localparam logic [7:0] FAULT_MASK_CMD   = 8'hfa;
	localparam logic [7:0] SUMMARY_CMD      = 8'hfb;
	localparam logic [7:0] PHASE_STAT_CMD   = 8'hfc;

	// ****************
	// reset values and writable bits
	// ****************
	localparam logic [7:0] ALERT_MASK_RST   = 8'h00;
	localparam logic [7:0] FAULT_MASK_RST   = 8'h00;
	localparam logic [7:0] ALERT_MASK_WMASK = 8'hcd;
	localparam logic [7:0] FAULT_MASK_WMASK = 8'hcd;

	// ****************
	// field positions
	// ****************
	localparam int OVOLT_BIT  = 7;
	localparam int OCURR_BIT  = 6;
	localparam int COMM_BIT   = 3;
	localparam int AUXV_BIT   = 2;
	localparam int POWER_BIT  = 0;
	localparam int SUM_FAULT  = 7;
	localparam int SUM_ALERT  = 6;
	localparam int SUM_READY  = 4;
	localparam int PH4_BIT    = 5;
	localparam int PH3_BIT    = 4;
	localparam int PH2_BIT    = 3;
	localparam int PSAVE_BIT  = 2;

	// ****************
	// status source flags, one per maskable group
	// ****************
	typedef struct packed {
		logic outputVoltageStatus;
		logic outputCurrentStatus;
		logic commMemoryLogicStatus;
		logic auxVoltageMonitor;
		logic outputPower;
	} famr_src_t;

	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] cmd;
		logic [7:0] wrData;
	} famr_req_t;

endpackage

//--- famr_regs.sv
// Purpose: alert/fault mask registers, summary and phase status
// Assumes: host interface decodes command codes into single-cycle strobes
// Notes:   alert and fault outputs are registered, one cycle behind sources
`timescale 1ns/10ps

// Function
// - alert mask bit 3 blocks alerts from comm/memory/logic status
// - alert mask bit 2 blocks alerts from aux voltage monitor limits
// - alert mask bit 0 blocks alerts from output power limit
// - fault mask bit 7 blocks faults from output voltage status
// - fault mask bit 6 blocks faults from output current status
// - fault mask bit 3 blocks faults from comm/memory/logic status
// - fault mask bit 0 blocks faults from output power limit
// - summary bit 5 is not power-good; it reads zero
// - phase status bit 5 shows fourth phase enabled
// - phase status bit 4 shows third phase enabled
// - phase status bit 3 shows second phase enabled
// - phase status bit 2 shows power-save input asserted
// - alert mask bits 7 and 6 block voltage and current alerts
module famr_regs (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire famr_pkg::famr_req_t  req,
	output logic [7:0]                rdData,
	output logic                      rdValid,
	input  wire famr_pkg::famr_src_t  alertSrc,
	input  wire famr_pkg::famr_src_t  faultSrc,
	input  wire logic                 ready,
	input  wire logic                 phase2En,
	input  wire logic                 phase3En,
	input  wire logic                 phase4En,
	input  wire logic                 powerSave_n,
	output logic                      alertOut,
	output logic                      faultOut
);

	// ****************
	// state
	// ****************
	logic [7:0] alertMask_r, alertMask_nxt;
	logic [7:0] faultMask_r, faultMask_nxt;
	logic       alert_r, alert_nxt, fault_r, fault_nxt;
	logic [7:0] rdData_r, rdData_nxt;
	logic       rdValid_r, rdValid_nxt;
	logic       psSync1_r, psSync2_r;
	logic [7:0] summary, phaseStat;

	// masked OR of sources; reserved bits never enter
	function automatic logic gate(input famr_pkg::famr_src_t s,
		input logic [7:0] m);
		gate = (s.outputVoltageStatus   & ~m[famr_pkg::OVOLT_BIT])
		     | (s.outputCurrentStatus   & ~m[famr_pkg::OCURR_BIT])
		     | (s.commMemoryLogicStatus & ~m[famr_pkg::COMM_BIT])
		     | (s.auxVoltageMonitor     & ~m[famr_pkg::AUXV_BIT])
		     | (s.outputPower           & ~m[famr_pkg::POWER_BIT]);
	endfunction

	// power-save pin comes from outside: two flops before use
	always_ff @(posedge clk) begin
		if (reset) begin
			psSync1_r <= 1'b0;
			psSync2_r <= 1'b0;
		end else begin
			psSync1_r <= ~powerSave_n;
			psSync2_r <= psSync1_r;
		end
	end

	// ****************
	// status composition
	// ****************
	always_comb begin
		summary = 8'h00; // bit 5 stays zero, power-good moved away
		summary[famr_pkg::SUM_FAULT] = fault_r;
		summary[famr_pkg::SUM_ALERT] = alert_r;
		summary[famr_pkg::SUM_READY] = ready;
		phaseStat = 8'h00;
		phaseStat[famr_pkg::PH4_BIT]   = phase4En;
		phaseStat[famr_pkg::PH3_BIT]   = phase3En;
		phaseStat[famr_pkg::PH2_BIT]   = phase2En;
		phaseStat[famr_pkg::PSAVE_BIT] = psSync2_r;
	end

	// ****************
	// next state
	// ****************
	always_comb begin
		alertMask_nxt = alertMask_r;
		faultMask_nxt = faultMask_r;
		if (req.wrEn && req.cmd == famr_pkg::ALERT_MASK_CMD)
			alertMask_nxt = req.wrData & famr_pkg::ALERT_MASK_WMASK;
		if (req.wrEn && req.cmd == famr_pkg::FAULT_MASK_CMD)
			faultMask_nxt = req.wrData & famr_pkg::FAULT_MASK_WMASK;
		// writes to status codes fall through untouched
		alert_nxt = gate(alertSrc, alertMask_r);
		fault_nxt = gate(faultSrc, faultMask_r);
		rdValid_nxt = req.rdEn;
		rdData_nxt = 8'h00;
		if (req.rdEn) begin
			case (req.cmd)
				famr_pkg::ALERT_MASK_CMD: rdData_nxt = alertMask_r;
				famr_pkg::FAULT_MASK_CMD: rdData_nxt = faultMask_r;
				famr_pkg::SUMMARY_CMD:    rdData_nxt = summary;
				famr_pkg::PHASE_STAT_CMD: rdData_nxt = phaseStat;
				default:                  rdData_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			alertMask_r <= famr_pkg::ALERT_MASK_RST;
			faultMask_r <= famr_pkg::FAULT_MASK_RST;
			alert_r     <= 1'b0;
			fault_r     <= 1'b0;
			rdData_r    <= 8'h00;
			rdValid_r   <= 1'b0;
		end else begin
			alertMask_r <= alertMask_nxt;
			faultMask_r <= faultMask_nxt;
			alert_r     <= alert_nxt;
			fault_r     <= fault_nxt;
			rdData_r    <= rdData_nxt;
			rdValid_r   <= rdValid_nxt;
		end
	end

	assign alertOut = alert_r;
	assign faultOut = fault_r;
	assign rdData   = rdData_r;
	assign rdValid  = rdValid_r;

	// ****************
	// checks
	// ****************
	alert_comm_a: assert property (@(posedge clk) disable iff (reset)
		alertMask_r[3] && !alertSrc.outputVoltageStatus &&
		!alertSrc.outputCurrentStatus && !alertSrc.auxVoltageMonitor &&
		!alertSrc.outputPower |=> !alertOut)
		else $error("comm status alert not masked");
	alert_aux_a: assert property (@(posedge clk) disable iff (reset)
		alertSrc == 5'b00010 |=> alertOut == !$past(alertMask_r[2]))
		else $error("aux monitor alert wrong");
	alert_pwr_a: assert property (@(posedge clk) disable iff (reset)
		alertSrc == 5'b00001 |=> alertOut == !$past(alertMask_r[0]))
		else $error("power alert wrong");
	fault_volt_a: assert property (@(posedge clk) disable iff (reset)
		faultSrc == 5'b10000 |=> faultOut == !$past(faultMask_r[7]))
		else $error("voltage fault wrong");
	fault_curr_a: assert property (@(posedge clk) disable iff (reset)
		faultSrc == 5'b01000 |=> faultOut == !$past(faultMask_r[6]))
		else $error("current fault wrong");
	fault_comm_a: assert property (@(posedge clk) disable iff (reset)
		faultSrc == 5'b00100 |=> faultOut == !$past(faultMask_r[3]))
		else $error("comm status fault wrong");
	fault_pwr_a: assert property (@(posedge clk) disable iff (reset)
		faultSrc == 5'b00001 |=> faultOut == !$past(faultMask_r[0]))
		else $error("power fault wrong");
	summary_pg_a: assert property (@(posedge clk) disable iff (reset)
		req.rdEn && req.cmd == famr_pkg::SUMMARY_CMD |=> !rdData[5])
		else $error("summary bit 5 set");
	phase_four_a: assert property (@(posedge clk) disable iff (reset)
		req.rdEn && req.cmd == famr_pkg::PHASE_STAT_CMD
		|=> rdData[5] == $past(phase4En))
		else $error("phase 4 status wrong");
	phase_three_a: assert property (@(posedge clk) disable iff (reset)
		req.rdEn && req.cmd == famr_pkg::PHASE_STAT_CMD
		|=> rdData[4] == $past(phase3En))
		else $error("phase 3 status wrong");
	phase_two_a: assert property (@(posedge clk) disable iff (reset)
		req.rdEn && req.cmd == famr_pkg::PHASE_STAT_CMD
		|=> rdData[3] == $past(phase2En))
		else $error("phase 2 status wrong");
	psave_sync_a: assert property (@(posedge clk) disable iff (reset)
		!powerSave_n [*3] ##0 req.rdEn && req.cmd == famr_pkg::PHASE_STAT_CMD
		|=> rdData[2])
		else $error("power save status wrong");
	alert_vi_a: assert property (@(posedge clk) disable iff (reset)
		alertSrc == 5'b10000 |=> alertOut == !$past(alertMask_r[7]))
		else $error("voltage alert wrong");
	alert_curr_a: assert property (@(posedge clk) disable iff (reset)
		alertSrc == 5'b01000 |=> alertOut == !$past(alertMask_r[6]))
		else $error("current alert wrong");
	// summary is captured a cycle before it shows, so compare old outputs
	summary_ro_a: assert property (@(posedge clk) disable iff (reset)
		req.rdEn && req.cmd == famr_pkg::SUMMARY_CMD
		|=> rdData[7] == $past(faultOut) && rdData[6] == $past(alertOut))
		else $error("summary fields wrong");
	ro_write_a: assert property (@(posedge clk) disable iff (reset)
		req.wrEn && (req.cmd == famr_pkg::SUMMARY_CMD ||
		req.cmd == famr_pkg::PHASE_STAT_CMD)
		|=> $stable(alertMask_r) && $stable(faultMask_r))
		else $error("status write changed a mask");
	mask_rsvd_a: assert property (@(posedge clk) disable iff (reset)
		(alertMask_r & ~famr_pkg::ALERT_MASK_WMASK) == 8'h00 &&
		(faultMask_r & ~famr_pkg::FAULT_MASK_WMASK) == 8'h00)
		else $error("reserved mask bit set");
	// a write lands whole except the reserved bits
	mask_wr_a: assert property (@(posedge clk) disable iff (reset)
		req.wrEn && req.cmd == famr_pkg::ALERT_MASK_CMD |=>
		alertMask_r == ($past(req.wrData) & famr_pkg::ALERT_MASK_WMASK))
		else $error("alert mask write wrong");
	rd_pulse_a: assert property (@(posedge clk) disable iff (reset)
		req.rdEn |=> rdValid)
		else $error("read reply missing");
	rd_idle_a: assert property (@(posedge clk) disable iff (reset)
		!req.rdEn |=> !rdValid && rdData == 8'h00)
		else $error("read data not idle");
	rd_unmapped_a: assert property (@(posedge clk) disable iff (reset)
		req.rdEn && (req.cmd < famr_pkg::ALERT_MASK_CMD ||
		req.cmd > famr_pkg::PHASE_STAT_CMD) |=> rdData == 8'h00)
		else $error("unmapped read not zero");

	alert_seen_c: cover property (@(posedge clk) disable iff (reset)
		alertOut);
	fault_seen_c: cover property (@(posedge clk) disable iff (reset)
		faultOut);
	mask_write_c: cover property (@(posedge clk) disable iff (reset)
		req.wrEn && req.cmd == famr_pkg::FAULT_MASK_CMD ##1 faultMask_r != 0);
	masked_src_c: cover property (@(posedge clk) disable iff (reset)
		alertSrc != 0 ##1 !alertOut);
	psave_read_c: cover property (@(posedge clk) disable iff (reset)
		req.rdEn && req.cmd == famr_pkg::PHASE_STAT_CMD && phaseStat[2]);

endmodule

//--- famr_host.sv
// Purpose: host model issuing one-cycle register strobes
// Assumes: strobes change on the falling edge
// Notes:   read reply sampled the cycle after the strobe
`timescale 1ns/10ps
module famr_host (
	input  wire logic           clk,
	output famr_pkg::famr_req_t req,
	input  wire logic [7:0]     rdData,
	input  wire logic           rdValid
);
	initial req = '0;
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(negedge clk);
		req = '{wrEn: 1'b1, rdEn: 1'b0, cmd: c, wrData: d};
		@(negedge clk);
		req = '0;
	endtask
	task automatic rd(input logic [7:0] c, output logic v,
		output logic [7:0] d);
		@(negedge clk);
		req = '{wrEn: 1'b0, rdEn: 1'b1, cmd: c, wrData: 8'h00};
		@(negedge clk);
		req = '0;
		v = rdValid;
		d = rdData;
	endtask
endmodule

//--- fault_alert_mask_status_regs_bench.sv
// Purpose: self-checking bench for the mask and status registers
// Assumes: inputs driven on the falling edge
// Notes:   outputs are checked one cycle after their cause
`timescale 1ns/10ps
module fault_alert_mask_status_regs_bench;
	logic                clk;
	logic                reset;
	logic                ready;
	logic                phase2En;
	logic                phase3En;
	logic                phase4En;
	logic                powerSave_n;
	famr_pkg::famr_src_t alertSrc;
	famr_pkg::famr_src_t faultSrc;
	famr_pkg::famr_req_t req;
	logic [7:0]          rdData;
	logic                rdValid;
	logic                alertOut;
	logic                faultOut;
	int                  err_total = 0;
	int                  cmp_count = 0;
	logic [7:0]          msk [5] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h01};

	famr_regs uut (.clk(clk), .reset(reset), .req(req), .rdData(rdData),
		.rdValid(rdValid), .alertSrc(alertSrc), .faultSrc(faultSrc),
		.ready(ready), .phase2En(phase2En), .phase3En(phase3En),
		.phase4En(phase4En), .powerSave_n(powerSave_n),
		.alertOut(alertOut), .faultOut(faultOut));
	famr_host host (.clk(clk), .req(req), .rdData(rdData),
		.rdValid(rdValid));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
		logic       v;
		logic [7:0] d;
		host.rd(c, v, d);
		check({7'h00, v}, 8'h01);
		check(d, e);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_reset_and_access;
		rdchk(famr_pkg::ALERT_MASK_CMD, 8'h00);
		rdchk(famr_pkg::FAULT_MASK_CMD, 8'h00);
		rdchk(famr_pkg::PHASE_STAT_CMD, 8'h00);
		rdchk(8'h00, 8'h00);
		host.wr(famr_pkg::ALERT_MASK_CMD, 8'hff);
		host.wr(famr_pkg::FAULT_MASK_CMD, 8'hff);
		host.wr(famr_pkg::SUMMARY_CMD, 8'hff);
		rdchk(famr_pkg::ALERT_MASK_CMD, 8'hcd);
		rdchk(famr_pkg::FAULT_MASK_CMD, 8'hcd);
		rdchk(famr_pkg::SUMMARY_CMD, 8'h00);
	endtask
	task automatic t_mid_reset;
		host.wr(famr_pkg::ALERT_MASK_CMD, 8'hff);
		host.wr(famr_pkg::FAULT_MASK_CMD, 8'hff);
		@(negedge clk);
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		rdchk(famr_pkg::ALERT_MASK_CMD, 8'h00);
		rdchk(famr_pkg::FAULT_MASK_CMD, 8'h00);
	endtask
	task automatic t_mask_each_source;
		for (int i = 0; i < 5; i++) begin
			host.wr(famr_pkg::ALERT_MASK_CMD, 8'h32);
			host.wr(famr_pkg::FAULT_MASK_CMD, 8'h32);
			@(negedge clk);
			alertSrc = famr_pkg::famr_src_t'(5'h10 >> i);
			faultSrc = famr_pkg::famr_src_t'(5'h10 >> i);
			@(negedge clk);
			check({6'h00, alertOut, faultOut}, 8'h03);
			rdchk(famr_pkg::SUMMARY_CMD, 8'hc0);
			host.wr(famr_pkg::ALERT_MASK_CMD, msk[i]);
			@(negedge clk);
			// only the alert side is masked here
			check({6'h00, alertOut, faultOut}, 8'h01);
			host.wr(famr_pkg::FAULT_MASK_CMD, msk[i]);
			@(negedge clk);
			check({6'h00, alertOut, faultOut}, 8'h00);
			alertSrc = '0;
			faultSrc = '0;
		end
	endtask
	task automatic t_phase_status;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			powerSave_n = (i != 0);
			phase2En = (i == 1);
			phase3En = (i == 2);
			phase4En = (i == 3);
			// power-save input passes a two-flop synchroniser
			repeat (3) @(negedge clk);
			rdchk(famr_pkg::PHASE_STAT_CMD, 8'h04 << i);
		end
		ready = 1'b1;
		@(negedge clk);
		rdchk(famr_pkg::SUMMARY_CMD, 8'h10);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end
	initial begin
		reset = 1'b1;
		ready = 1'b0;
		phase2En = 1'b0;
		phase3En = 1'b0;
		phase4En = 1'b0;
		powerSave_n = 1'b1;
		alertSrc = '0;
		faultSrc = '0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		t_reset_and_access();
		t_mask_each_source();
		t_phase_status();
		t_mid_reset();
		give_verdict();
	end
endmodule
